/* design/handshake_pkg.sv */
package handshake_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   // slowed path from the data-valid line back to the accepted flip-flop
   localparam int DAV_SET_DELAY_NS = 40;
   localparam int DAV_SET_CYC_I = (DAV_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DAV_SET_CYC = (DAV_SET_CYC_I < 1) ? 1 : DAV_SET_CYC_I;

   // ----------------------------------------
   // widths and sizes
   // ----------------------------------------
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 5;
   localparam int LOOKUP_IDX_W = 5;
   localparam int FIFO_DEPTH = 16;

   // one bit per lookup state: 1 interrupts the cpu, 0 completes the handshake
   localparam logic [31:0] LOOKUP_INT_MAP = 32'hf777_0808;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic DAC_RST = 1'b1;
   localparam logic RX_EN_RST = 1'b0;
   localparam logic RELEASED_RST = 1'b1;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

   // bus lines as seen at the pins, all active low
   typedef struct packed {
      logic atn_n;
      logic dav_n;
      logic nrfd_n;
      logic ndac_n;
      logic [BYTE_W-1:0] dio_n;
   } bus_lines_t;

   localparam bus_lines_t BUS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 8'hff};

   typedef enum logic [0:0] {ACC_IDLE, ACC_WAIT_CPU} acc_state_t;

endpackage

/* design/handshake_interface.sv */
`timescale 1ns/1ps
// Summary of operation
// RQ1 - listen or attention enables acceptor line drive
// RQ2 - flip-flop set: ready, nrfd released, ndac low
// RQ3 - controller lowers data-valid after all ready
// RQ4 - data-valid low: interrupt cpu or accept
// RQ5 - cpu clears accepted flip-flop via clear line
// RQ6 - flip-flop cleared: flag low, ndac released
// RQ7 - controller raises data-valid after ndac released
// RQ8 - data-valid high sets flip-flop after delay
// RQ9 - no listen, no attention: acceptor drive off
// RQ10 - cpu reads nrfd and ndac when talking
// RQ11 - data-valid driven by firmware bit when talking
// RQ12 - lookup needs ready, enable, latch, valid
// RQ13 - acceptor enable on listen or attention
// RQ14 - receive latch gates lookup, off when talking
// RQ15 - lookup picks one of 32 output states
// RQ16 - handshake as bystander, attention, or addressed
// RQ17 - bystander never pulls nrfd or ndac low
// RQ18 - idle flip-flop set, nrfd released on attention
// RQ19 - not talking: receive direction to comparator
// RQ20 - compare data lines one-five with switches
// RQ21 - talker select turns transceivers to send
// RQ22 - bus inputs pass two-stage synchronisers
// RQ23 - reset: flip-flop set, off bus, no interrupt

// ----------------------------------------
// byte fifo
// ----------------------------------------
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic ready_reg, ready_next, valid_reg, valid_next;
   logic push, pop;

   assign push = in_valid_in && ready_reg;
   assign pop = out_ready_in && valid_reg;
   assign in_ready_out = ready_reg;
   assign out_valid_out = valid_reg;
   assign out_data_out = mem_reg[rd_reg];

   always_comb begin
      wr_next = push ? PW'(wr_reg + 1'b1) : wr_reg;
      rd_next = pop ? PW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = CW'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = CW'(cnt_reg - 1'b1);
      end
      ready_next = (cnt_next != FULL_CNT);
      valid_next = (cnt_next != '0);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
         valid_reg <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
         valid_reg <= valid_next;
      end
   end

   // storage needs no reset; empty flag guards the output
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         always_ff @(posedge clk_in) begin
            if (push && wr_reg == PW'(gi)) begin
               mem_reg[gi] <= in_data_in;
            end
         end
      end
   endgenerate
endmodule

// ----------------------------------------
// handshake and interface control
// ----------------------------------------
module handshake_interface
   import handshake_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire bus_lines_t bus_in,
   output logic nrfd_oe_n_out,
   output logic ndac_oe_n_out,
   output logic dav_out,
   output logic dav_oe_n_out,
   output logic [BYTE_W-1:0] dio_out,
   output logic dio_oe_n_out,
   input wire logic listen_addressed_n_in,
   input wire logic talk_select_n_in,
   input wire logic valid_drive_bit_in,
   input wire logic [BYTE_W-1:0] tx_data_in,
   input wire logic rx_enable_set_in,
   input wire logic rx_enable_clear_in,
   input wire logic cpu_accept_clear_n_in,
   input wire logic [ADDR_W-1:0] addr_switch_in,
   output logic cpu_interrupt_n_out,
   output logic nrfd_seen_out,
   output logic ndac_seen_out,
   output logic addr_match_out,
   output logic accepted_flag_n_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output logic [BYTE_W-1:0] rx_data_out
);
   // ----------------------------------------
   // reset release and bus synchronisers
   // ----------------------------------------
   logic rst_meta_reg, rst_sync_reg;
   bus_lines_t bus_meta_reg, bus_s;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         bus_meta_reg <= BUS_IDLE; // RQ22
         bus_s <= BUS_IDLE;
      end else begin
         bus_meta_reg <= bus_in; // RQ22
         bus_s <= bus_meta_reg;
      end
   end

   // ----------------------------------------
   // acceptor state
   // ----------------------------------------
   logic dac_reg, dac_next;
   logic rx_en_reg, rx_en_next;
   logic [DAV_SET_CYC-1:0] dly_reg, dly_next;
   acc_state_t state_reg, state_next;
   logic acceptor_enable_n, rx_ready_n, valid_seen_n, lookup_enable_n;
   logic [LOOKUP_IDX_W-1:0] lookup_idx;
   logic lookup_int, accept_strobe, push, cpu_clear, fifo_ready;
   logic [BYTE_W-1:0] rx_byte;

   assign acceptor_enable_n = listen_addressed_n_in & bus_s.atn_n; // RQ13
   assign rx_ready_n = !dac_reg;
   assign valid_seen_n = bus_s.dav_n;
   assign rx_byte = ~bus_s.dio_n;
   assign lookup_enable_n = !(!rx_ready_n && !acceptor_enable_n
                              && rx_en_reg && !valid_seen_n); // RQ12
   assign lookup_idx = {bus_s.atn_n, rx_byte[3:0]};
   assign lookup_int = LOOKUP_INT_MAP[lookup_idx]; // RQ15
   assign accept_strobe = (state_reg == ACC_IDLE) && !lookup_enable_n && !lookup_int;
   // a full fifo holds the handshake off until the cpu drains it
   assign push = (state_reg == ACC_IDLE) && !lookup_enable_n && lookup_int && fifo_ready;
   assign cpu_clear = !cpu_accept_clear_n_in;

   always_comb begin
      dly_next = {dly_reg[DAV_SET_CYC-2:0], bus_s.dav_n};
      rx_en_next = rx_en_reg;
      if (rx_enable_set_in) begin
         rx_en_next = 1'b1;
      end
      if (rx_enable_clear_in || !talk_select_n_in) begin
         rx_en_next = 1'b0; // RQ14
      end
      dac_next = dac_reg;
      if (accept_strobe || cpu_clear) begin
         dac_next = 1'b0; // RQ4 RQ5
      end
      if (&dly_reg) begin
         dac_next = 1'b1; // RQ8
      end
      state_next = state_reg;
      unique case (state_reg)
         ACC_IDLE: begin
            if (push) begin
               state_next = ACC_WAIT_CPU; // RQ4
            end
         end
         ACC_WAIT_CPU: begin
            if (cpu_clear) begin
               state_next = ACC_IDLE; // RQ5
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         dac_reg <= DAC_RST; // RQ23
         rx_en_reg <= RX_EN_RST;
         dly_reg <= '1;
         state_reg <= ACC_IDLE;
      end else begin
         dac_reg <= dac_next;
         rx_en_reg <= rx_en_next;
         dly_reg <= dly_next;
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // pin drivers and cpu-facing status
   // ----------------------------------------
   logic nrfd_oe_n_next, ndac_oe_n_next, dav_next, dav_oe_n_next, dio_oe_n_next;
   logic int_n_next, match_next;
   logic [BYTE_W-1:0] dio_next;

   always_comb begin
      // RQ1 RQ2 RQ6 RQ9 RQ16 RQ17 RQ18
      nrfd_oe_n_next = !(!acceptor_enable_n && rx_ready_n);
      ndac_oe_n_next = !(!acceptor_enable_n && dac_reg);
      dav_next = !valid_drive_bit_in; // RQ11
      dav_oe_n_next = talk_select_n_in; // RQ11
      dio_next = ~tx_data_in; // RQ21
      dio_oe_n_next = talk_select_n_in; // RQ19 RQ21
      int_n_next = (state_next != ACC_WAIT_CPU); // RQ4
      match_next = (rx_byte[ADDR_W-1:0] == addr_switch_in); // RQ20
   end

   always_ff @(posedge clk_in or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         nrfd_oe_n_out <= RELEASED_RST; // RQ23
         ndac_oe_n_out <= RELEASED_RST;
         dav_out <= RELEASED_RST;
         dav_oe_n_out <= RELEASED_RST;
         dio_out <= BYTE_RST;
         dio_oe_n_out <= RELEASED_RST;
         cpu_interrupt_n_out <= RELEASED_RST;
         nrfd_seen_out <= RELEASED_RST;
         ndac_seen_out <= RELEASED_RST;
         addr_match_out <= 1'b0;
         accepted_flag_n_out <= DAC_RST;
      end else begin
         nrfd_oe_n_out <= nrfd_oe_n_next;
         ndac_oe_n_out <= ndac_oe_n_next;
         dav_out <= dav_next;
         dav_oe_n_out <= dav_oe_n_next;
         dio_out <= dio_next;
         dio_oe_n_out <= dio_oe_n_next;
         cpu_interrupt_n_out <= int_n_next;
         nrfd_seen_out <= bus_s.nrfd_n; // RQ10
         ndac_seen_out <= bus_s.ndac_n; // RQ10
         addr_match_out <= match_next;
         accepted_flag_n_out <= dac_reg;
      end
   end

   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_sync_reg),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in(rx_byte),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_data_out)
   );

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_sync_reg);

   a_bystander_off_bus: assert property ( // RQ17
      acceptor_enable_n |=> nrfd_oe_n_out && ndac_oe_n_out)
      else $error("bystander pulled a handshake line");
   a_ready_drive: assert property ( // RQ2
      !acceptor_enable_n && dac_reg |=> nrfd_oe_n_out && !ndac_oe_n_out)
      else $error("ready state not driven");
   a_accept_release: assert property ( // RQ6
      accept_strobe && !(&dly_reg) && !acceptor_enable_n ##1 !acceptor_enable_n
      |=> ndac_oe_n_out && !accepted_flag_n_out)
      else $error("ndac not released after accept");
   a_cpu_clear_dac: assert property ( // RQ5
      state_reg == ACC_WAIT_CPU && cpu_clear && !(&dly_reg)
      |=> !dac_reg ##1 cpu_interrupt_n_out)
      else $error("cpu clear ignored");
   a_dav_sets_dac: assert property ( // RQ8
      bus_s.dav_n [*3] |=> dac_reg)
      else $error("accepted flip-flop not set by data-valid high");
   a_dav_driver: assert property ( // RQ11
      !talk_select_n_in |=> !dav_oe_n_out && dav_out == !$past(valid_drive_bit_in))
      else $error("data-valid driver wrong while talking");
   a_dav_off: assert property ( // RQ11
      talk_select_n_in |=> dav_oe_n_out && dio_oe_n_out)
      else $error("driver on while not talking");
   a_lookup_gate: assert property ( // RQ12
      state_reg == ACC_IDLE && lookup_enable_n |=> state_reg == ACC_IDLE)
      else $error("lookup acted while disabled");
   a_int_on_byte: assert property ( // RQ4
      push |=> !cpu_interrupt_n_out && state_reg == ACC_WAIT_CPU)
      else $error("no interrupt for pushed byte");
   a_talk_kills_rx: assert property ( // RQ14
      !talk_select_n_in |=> !rx_en_reg)
      else $error("receive latch set while talking");
   a_addr_match: assert property ( // RQ20
      ##1 addr_match_out == ($past(rx_byte[ADDR_W-1:0]) == $past(addr_switch_in)))
      else $error("address compare wrong");

   c_accept: cover property (accept_strobe ##[1:20] dac_reg);
   c_interrupt: cover property (push ##[1:20] cpu_clear);
   c_fifo_full: cover property (!fifo_ready);
   c_talk: cover property (!dav_oe_n_out ##1 !ndac_seen_out);
endmodule

/* verification/bus_controller.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bus controller model
// ----------------------------------------
module bus_controller (
   input wire logic clk_in,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   output logic atn_n_out,
   output logic dav_n_out,
   output logic ndac_pull_n_out,
   output logic [7:0] dio_n_out
);
   initial begin
      atn_n_out = 1'h1;
      dav_n_out = 1'h1;
      ndac_pull_n_out = 1'h1;
      dio_n_out = 8'hff;
   end

   // pick 0 waits for nrfd, 1 for ndac; gives up after 300 cycles
   task automatic wait_line(input bit pick, output bit ok);
      int n;
      n = 0;
      while ((pick ? ndac_in : nrfd_in) !== 1'h1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      ok = (n < 300);
   endtask

   task automatic send_byte(input logic atn_n, input logic [7:0] b, output bit ok);
      bit ok1;
      bit ok2;
      @(posedge clk_in);
      atn_n_out <= atn_n;
      dio_n_out <= ~b;
      // settle time so listeners see attention and data before valid
      repeat (6) @(posedge clk_in);
      wait_line(1'b0, ok1);
      dav_n_out <= 1'h0;
      // let the valid level reach the bus before looking for ndac released
      @(posedge clk_in);
      wait_line(1'b1, ok2);
      dav_n_out <= 1'h1;
      // released data lines float up to the bus termination
      dio_n_out <= 8'hff;
      ok = ok1 && ok2;
   endtask
endmodule

/* verification/handshake_interface_test.sv */
`timescale 1ns/1ps
module handshake_interface_test
   import handshake_pkg::*;
;
   typedef struct packed {logic atn_n; logic lst_n; logic [7:0] b; logic intr;} row_t;
   row_t rows [12] = '{'{1'h1, 1'h0, 8'h41, 1'h1}, '{1'h1, 1'h0, 8'h43, 1'h0},
      '{1'h1, 1'h0, 8'h57, 1'h0}, '{1'h1, 1'h0, 8'h5b, 1'h0}, '{1'h1, 1'h0, 8'h5f, 1'h1},
      '{1'h1, 1'h0, 8'h3c, 1'h1}, '{1'h0, 1'h1, 8'h23, 1'h1}, '{1'h0, 1'h1, 8'h2b, 1'h1},
      '{1'h0, 1'h1, 8'h3f, 1'h0}, '{1'h0, 1'h1, 8'h20, 1'h0}, '{1'h1, 1'h1, 8'h41, 1'h0},
      '{1'h1, 1'h1, 8'h42, 1'h0}};
   logic clk_in = 1'h0;
   logic nrst_in = 1'h0;
   logic lst_n = 1'h1, talk_n = 1'h1, vbit = 1'h0, rx_set = 1'h0, clr_n = 1'h1, rdy = 1'h1;
   logic rx_clr = 1'h0;
   logic [7:0] tx = 8'h00;
   logic nrfd_oe_n, ndac_oe_n, dav_o, dav_oe_n, dio_oe_n, int_n, nrfd_s, ndac_s, match;
   logic acc_n, rx_v, p_atn, p_dav, p_ndac, nrfd_w, ndac_w, dav_w;
   logic [7:0] dio_o, rx_d, p_dio, dio_w;
   int fail_count = 0, n_compared = 0;
   bit saw_int, saw_pull, saw_match, ok, ok17;
   logic [7:0] got_q [$];

   // open-drain lines resolve against the pull-up
   assign nrfd_w = nrfd_oe_n;
   assign ndac_w = ndac_oe_n & p_ndac;
   assign dav_w = (dav_oe_n ? 1'h1 : dav_o) & p_dav;
   assign dio_w = (dio_oe_n ? 8'hff : dio_o) & p_dio;

   always #10 clk_in = ~clk_in;

   bus_controller bus_controller_inst (.clk_in(clk_in), .nrfd_in(nrfd_w), .ndac_in(ndac_w),
      .atn_n_out(p_atn), .dav_n_out(p_dav), .ndac_pull_n_out(p_ndac), .dio_n_out(p_dio));

   handshake_interface handshake_interface_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .bus_in({p_atn, dav_w, nrfd_w, ndac_w, dio_w}), .nrfd_oe_n_out(nrfd_oe_n),
      .ndac_oe_n_out(ndac_oe_n), .dav_out(dav_o), .dav_oe_n_out(dav_oe_n), .dio_out(dio_o),
      .dio_oe_n_out(dio_oe_n), .listen_addressed_n_in(lst_n), .talk_select_n_in(talk_n),
      .valid_drive_bit_in(vbit), .tx_data_in(tx), .rx_enable_set_in(rx_set),
      .rx_enable_clear_in(rx_clr), .cpu_accept_clear_n_in(clr_n), .addr_switch_in(5'h03),
      .cpu_interrupt_n_out(int_n), .nrfd_seen_out(nrfd_s), .ndac_seen_out(ndac_s),
      .addr_match_out(match), .accepted_flag_n_out(acc_n), .rx_valid_out(rx_v),
      .rx_ready_in(rdy), .rx_data_out(rx_d));

   // firmware stand-in: clear the accepted flip-flop whenever a byte waits
   always @(posedge clk_in) begin
      clr_n <= !(int_n === 1'h0 && clr_n === 1'h1);
      if (rx_v === 1'h1 && rdy === 1'h1) got_q.push_back(rx_d);
      if (int_n === 1'h0) saw_int = 1;
      if (nrfd_oe_n === 1'h0 || ndac_oe_n === 1'h0) saw_pull = 1;
      if (match === 1'h1) saw_match = 1;
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      check(what, {7'h0, exp}, {7'h0, got});
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #(20 * 20000);
      fail_count++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge clk_in);
      chk1("reset nrfd oe", 1'h1, nrfd_oe_n);
      chk1("reset ndac oe", 1'h1, ndac_oe_n);
      chk1("reset dav oe", 1'h1, dav_oe_n);
      chk1("reset int", 1'h1, int_n);
      chk1("reset flag", 1'h1, acc_n);
      chk1("reset fifo", 1'h0, rx_v);
      nrst_in <= 1'h1;
      repeat (3) @(posedge clk_in);
      rx_set <= 1'h1;
      lst_n <= 1'h0;
      @(posedge clk_in);
      rx_set <= 1'h0;
      repeat (3) @(posedge clk_in);
      chk1("listen nrfd oe", 1'h1, nrfd_oe_n);
      chk1("listen ndac oe", 1'h0, ndac_oe_n);
      chk1("listen flag", 1'h1, acc_n);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         lst_n <= rows[i].lst_n;
         bus_controller_inst.atn_n_out <= rows[i].atn_n;
         repeat (6) @(posedge clk_in);
         saw_int = 0;
         saw_pull = 0;
         saw_match = 0;
         got_q.delete();
         bus_controller_inst.send_byte(rows[i].atn_n, rows[i].b, ok);
         repeat (20) @(posedge clk_in);
         chk1("handshake", 1'h1, ok);
         chk1("interrupt", rows[i].intr, saw_int);
         chk1("match", rows[i].b[4:0] == 5'h03, saw_match);
         if (rows[i].intr) check("rx byte", rows[i].b, got_q[0]);
         if (rows[i].lst_n && rows[i].atn_n) chk1("bystander", 1'h0, saw_pull);
      end
      $display("test rows done");
      lst_n <= 1'h0;
      rdy <= 1'h0;
      got_q.delete();
      for (int i = 0; i < 16; i++) begin
         bus_controller_inst.send_byte(1'h1, 8'(i * 16), ok);
         chk1("fill", 1'h1, ok);
      end
      fork
         bus_controller_inst.send_byte(1'h1, 8'h0f, ok17);
      join_none
      repeat (60) @(posedge clk_in);
      chk1("full int", 1'h1, int_n);
      chk1("full ndac held", 1'h0, ndac_oe_n);
      rdy <= 1'h1;
      repeat (200) @(posedge clk_in);
      chk1("stalled done", 1'h1, ok17);
      check("drain count", 8'd17, 8'(got_q.size()));
      for (int i = 0; i < 17; i++) check("drain", (i < 16) ? 8'(i * 16) : 8'h0f, got_q[i]);
      chk1("empty", 1'h0, rx_v);
      $display("test fifo done");
      lst_n <= 1'h1;
      talk_n <= 1'h0;
      vbit <= 1'h1;
      tx <= 8'ha5;
      bus_controller_inst.ndac_pull_n_out <= 1'h0;
      saw_int = 0;
      repeat (8) @(posedge clk_in);
      chk1("talk dav", 1'h0, dav_w);
      check("talk data", 8'h5a, dio_w);
      chk1("talk ndac seen", 1'h0, ndac_s);
      chk1("talk nrfd seen", 1'h1, nrfd_s);
      chk1("talk nrfd oe", 1'h1, nrfd_oe_n);
      chk1("talk own byte", 1'h0, saw_int);
      talk_n <= 1'h1;
      bus_controller_inst.ndac_pull_n_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      chk1("dav released", 1'h1, dav_w);
      check("data released", 8'hff, dio_w);
      $display("test talker done");
      // talking cleared the receive latch, so a listened byte must stall
      lst_n <= 1'h0;
      saw_int = 0;
      repeat (4) @(posedge clk_in);
      bus_controller_inst.send_byte(1'h1, 8'h41, ok);
      chk1("talk latch handshake", 1'h0, ok);
      chk1("talk latch int", 1'h0, saw_int);
      rx_set <= 1'h1;
      @(posedge clk_in);
      rx_set <= 1'h0;
      saw_int = 0;
      got_q.delete();
      bus_controller_inst.send_byte(1'h1, 8'h41, ok);
      repeat (20) @(posedge clk_in);
      chk1("latch set handshake", 1'h1, ok);
      chk1("latch set int", 1'h1, saw_int);
      check("latch set byte", 8'h41, got_q[0]);
      // set and clear together: clear must win
      rx_set <= 1'h1;
      rx_clr <= 1'h1;
      @(posedge clk_in);
      rx_set <= 1'h0;
      rx_clr <= 1'h0;
      saw_int = 0;
      bus_controller_inst.send_byte(1'h1, 8'h41, ok);
      chk1("clear wins handshake", 1'h0, ok);
      chk1("clear wins int", 1'h0, saw_int);
      $display("test latch done");
      stop_test();
   end
endmodule
